// >>> verilog/utb_consts.svh
// Address map, bit positions and reset values of the serial port
`ifndef UTB_CONSTS_SVH
`define UTB_CONSTS_SVH
// Register byte offsets
`define UTB_A_DATA 8'h00
`define UTB_A_STAT 8'h04
`define UTB_A_CTRLB 8'h08
`define UTB_A_CTRLC 8'h0c
`define UTB_A_BAUD 8'h10
// status_ctrl_a bits
`define UTB_ST_RXC 7
`define UTB_ST_TXC 6
`define UTB_ST_UDRE 5
`define UTB_ST_FE 4
`define UTB_ST_DOR 3
`define UTB_ST_PE 2
// ctrl_b bits
`define UTB_CB_TXCIE 6
`define UTB_CB_UDRIE 5
`define UTB_CB_RXEN 4
`define UTB_CB_TXEN 3
`define UTB_CB_RX9 1
`define UTB_CB_TX9 0
// ctrl_c bits
`define UTB_CC_PHI 6
`define UTB_CC_PODD 5
`define UTB_CC_STOP2 4
`define UTB_CC_CSZ_MSB 3
`define UTB_CC_CSZ_LSB 1
`define UTB_CC_SYNC 0
// Receive FIFO word fields
`define UTB_W_FE 9
`define UTB_W_DOR 10
`define UTB_W_PE 11
// Character sizes, FIFO full count and baud reset value
`define UTB_CSZ_9 3'h7
`define UTB_CSZ_RST 3'h3
`define UTB_CHR_MIN 4'h5
`define UTB_CHR_MAX 4'h9
`define UTB_FIFO_FULL 2'h2
`define UTB_BAUD_RST 12'h00f
`endif

// >>> verilog/utb_pkg.sv
// Types shared by the serial port core
package utb_pkg;
  typedef enum logic [2:0] {
    UTB_TX_IDLE = 3'b000, UTB_TX_START = 3'b001, UTB_TX_DATA = 3'b010,
    UTB_TX_PAR = 3'b011, UTB_TX_STOP1 = 3'b100, UTB_TX_STOP2 = 3'b101
  } utb_tx_st_t;
  typedef enum logic [2:0] {
    UTB_RX_IDLE = 3'b000, UTB_RX_START = 3'b001, UTB_RX_DATA = 3'b010,
    UTB_RX_PAR = 3'b011, UTB_RX_STOP = 3'b100
  } utb_rx_st_t;
  typedef struct packed {
    logic txen, rxen, udrie, txcie, tx9, p_hi, p_odd, stop2, sync;
    logic [2:0] csz;
    logic [11:0] baud;
  } utb_cfg_t;
  typedef struct packed {
    logic hready;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    utb_cfg_t cfg;
    logic [8:0] tbuf;
    logic tbuf_full;
    utb_tx_st_t tst;
    logic [8:0] tsh;
    logic [3:0] tbit;
    logic [11:0] tcnt;
    logic tpar, tx_done, tx_act, txd;
    utb_rx_st_t rst;
    logic [11:0] rcnt;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic rpar, rwait, dor_pend;
    logic [11:0] rwait_word;
    logic [1:0][11:0] fifo;
    logic [1:0] fcnt;
    logic sclk_prev, irq_empty, irq_done;
  } utb_state_t;
endpackage

// >>> verilog/utb_core.sv
// Serial port core: AHB-Lite registers, transmit buffer, two-deep receive FIFO
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "utb_consts.svh"
module utb_core (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic serial_in_pin_in,
  input wire logic sync_clock_pin_in,
  input wire logic global_irq_en_in,
  input wire logic tx_done_ack_in,
  output logic serial_out_pin_out,
  output logic serial_out_oe_out,
  output logic rx_pin_claim_out,
  output logic irq_empty_out,
  output logic irq_done_out
);
  import utb_pkg::*;

  utb_state_t s_reg;
  utb_state_t s_next;
  logic sclk_edge;
  logic tx_tick;
  logic rx_tick;
  logic [3:0] nbits;
  logic [8:0] dmask;

  // Bit clocks; the pin input is already synchronous, so a plain edge detect
  assign sclk_edge = sync_clock_pin_in & ~s_reg.sclk_prev;
  assign tx_tick = s_reg.cfg.sync ? sclk_edge : (s_reg.tcnt == 12'h000);
  assign rx_tick = s_reg.cfg.sync ? sclk_edge : (s_reg.rcnt == 12'h000);
  // Character length and data mask from the size field
  assign nbits = (s_reg.cfg.csz == `UTB_CSZ_9) ? `UTB_CHR_MAX :
                 (`UTB_CHR_MIN + {2'b00, s_reg.cfg.csz[1:0]});
  assign dmask = ~(9'h1ff << nbits);

  // Whole next state
  always_comb begin
    logic done_set;
    logic [11:0] word;
    s_next = s_reg;
    done_set = 1'b0;
    word = 12'h000;
    s_next.sclk_prev = sync_clock_pin_in;

    // Transmitter; runs before the bus write so a fresh write is never lost
    if (s_reg.tst != UTB_TX_IDLE) begin
      s_next.tcnt = tx_tick ? s_reg.cfg.baud : (s_reg.tcnt - 12'h001);
    end
    unique case (s_reg.tst)
      UTB_TX_IDLE: begin
        if (s_reg.tbuf_full && s_reg.tx_act) begin
          s_next.tsh = s_reg.tbuf & dmask;
          s_next.tpar = (^(s_reg.tbuf & dmask)) ^ s_reg.cfg.p_odd;
          s_next.tbuf_full = 1'b0;
          s_next.tbit = 4'h0;
          s_next.tcnt = s_reg.cfg.baud;
          s_next.tst = UTB_TX_START;
        end
      end
      UTB_TX_START: begin
        if (tx_tick) begin
          s_next.tst = UTB_TX_DATA;
        end
      end
      UTB_TX_DATA: begin
        if (tx_tick) begin
          if (s_reg.tbit == nbits - 4'h1) begin
            s_next.tst = s_reg.cfg.p_hi ? UTB_TX_PAR : UTB_TX_STOP1;
          end else begin
            s_next.tbit = s_reg.tbit + 4'h1;
          end
        end
      end
      UTB_TX_PAR: begin
        if (tx_tick) begin
          s_next.tst = UTB_TX_STOP1;
        end
      end
      UTB_TX_STOP1, UTB_TX_STOP2: begin
        if (tx_tick) begin
          if (s_reg.tst == UTB_TX_STOP1 && s_reg.cfg.stop2) begin
            s_next.tst = UTB_TX_STOP2;
          end else if (s_reg.tbuf_full) begin
            // Back to back: next frame starts with no idle gap
            s_next.tsh = s_reg.tbuf & dmask;
            s_next.tpar = (^(s_reg.tbuf & dmask)) ^ s_reg.cfg.p_odd;
            s_next.tbuf_full = 1'b0;
            s_next.tbit = 4'h0;
            s_next.tst = UTB_TX_START;
          end else begin
            s_next.tst = UTB_TX_IDLE;
            s_next.tx_done = 1'b1;
            done_set = 1'b1;
          end
        end
      end
      default: s_next.tst = UTB_TX_IDLE;
    endcase

    // Interrupt service clears done, but a set in the same cycle wins
    if (tx_done_ack_in && !done_set) begin
      s_next.tx_done = 1'b0;
    end

    // Bus data phase of a write
    if (s_reg.wr_pend) begin
      s_next.wr_pend = 1'b0;
      unique case (s_reg.wr_addr)
        `UTB_A_DATA: begin
          s_next.tbuf = {s_reg.cfg.tx9, hwdata[7:0]};
          s_next.tbuf_full = 1'b1;
        end
        `UTB_A_STAT: begin
          // Only the done flag is writable; the rest are hardware state
          if (hwdata[`UTB_ST_TXC] && !done_set) begin
            s_next.tx_done = 1'b0;
          end
        end
        `UTB_A_CTRLB: begin
          s_next.cfg.txcie = hwdata[`UTB_CB_TXCIE];
          s_next.cfg.udrie = hwdata[`UTB_CB_UDRIE];
          s_next.cfg.rxen = hwdata[`UTB_CB_RXEN];
          s_next.cfg.txen = hwdata[`UTB_CB_TXEN];
          s_next.cfg.tx9 = hwdata[`UTB_CB_TX9];
        end
        `UTB_A_CTRLC: begin
          s_next.cfg.p_hi = hwdata[`UTB_CC_PHI];
          s_next.cfg.p_odd = hwdata[`UTB_CC_PODD];
          s_next.cfg.stop2 = hwdata[`UTB_CC_STOP2];
          s_next.cfg.csz = hwdata[`UTB_CC_CSZ_MSB:`UTB_CC_CSZ_LSB];
          s_next.cfg.sync = hwdata[`UTB_CC_SYNC];
        end
        `UTB_A_BAUD: s_next.cfg.baud = hwdata[11:0];
        default: ;
      endcase
    end

    // Bus address phase; reads answer one cycle later from the flop
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        s_next.wr_pend = 1'b1;
        s_next.wr_addr = haddr[7:0];
      end else begin
        s_next.hrdata = 32'h0000_0000;
        unique case (haddr[7:0])
          `UTB_A_DATA: begin
            s_next.hrdata[7:0] = s_reg.fifo[0][7:0];
            if (s_reg.fcnt != 2'h0) begin
              s_next.fifo[0] = s_reg.fifo[1];
              s_next.fcnt = s_reg.fcnt - 2'h1;
            end
          end
          `UTB_A_STAT: begin
            s_next.hrdata[`UTB_ST_RXC] = (s_reg.fcnt != 2'h0);
            s_next.hrdata[`UTB_ST_TXC] = s_reg.tx_done;
            s_next.hrdata[`UTB_ST_UDRE] = ~s_reg.tbuf_full;
            s_next.hrdata[`UTB_ST_FE] = s_reg.fifo[0][`UTB_W_FE] & (s_reg.fcnt != 2'h0);
            s_next.hrdata[`UTB_ST_DOR] = s_reg.fifo[0][`UTB_W_DOR] & (s_reg.fcnt != 2'h0);
            s_next.hrdata[`UTB_ST_PE] = s_reg.fifo[0][`UTB_W_PE] & (s_reg.fcnt != 2'h0);
          end
          `UTB_A_CTRLB: begin
            s_next.hrdata[`UTB_CB_TXCIE] = s_reg.cfg.txcie;
            s_next.hrdata[`UTB_CB_UDRIE] = s_reg.cfg.udrie;
            s_next.hrdata[`UTB_CB_RXEN] = s_reg.cfg.rxen;
            s_next.hrdata[`UTB_CB_TXEN] = s_reg.cfg.txen;
            s_next.hrdata[`UTB_CB_RX9] = s_reg.fifo[0][8];
            s_next.hrdata[`UTB_CB_TX9] = s_reg.cfg.tx9;
          end
          `UTB_A_CTRLC: begin
            s_next.hrdata[`UTB_CC_PHI] = s_reg.cfg.p_hi;
            s_next.hrdata[`UTB_CC_PODD] = s_reg.cfg.p_odd;
            s_next.hrdata[`UTB_CC_STOP2] = s_reg.cfg.stop2;
            s_next.hrdata[`UTB_CC_CSZ_MSB:`UTB_CC_CSZ_LSB] = s_reg.cfg.csz;
            s_next.hrdata[`UTB_CC_SYNC] = s_reg.cfg.sync;
          end
          `UTB_A_BAUD: s_next.hrdata[11:0] = s_reg.cfg.baud;
          default: ;
        endcase
      end
    end

    // A character parked in rwait_word moves as soon as room appears
    if (s_reg.rwait && s_next.fcnt != `UTB_FIFO_FULL) begin
      word = s_reg.rwait_word;
      word[`UTB_W_DOR] = s_reg.dor_pend;
      s_next.fifo[s_next.fcnt[0]] = word;
      s_next.fcnt = s_next.fcnt + 2'h1;
      s_next.rwait = 1'b0;
      s_next.dor_pend = 1'b0;
    end

    // Receiver
    if (s_reg.rst != UTB_RX_IDLE) begin
      s_next.rcnt = rx_tick ? s_reg.cfg.baud : (s_reg.rcnt - 12'h001);
    end
    unique case (s_reg.rst)
      UTB_RX_IDLE: begin
        if (!serial_in_pin_in && (!s_reg.cfg.sync || sclk_edge)) begin
          if (s_next.rwait && s_next.fcnt == `UTB_FIFO_FULL) begin
            s_next.dor_pend = 1'b1;
            s_next.rwait = 1'b0;
          end
          s_next.rsh = 9'h000;
          s_next.rbit = 4'h0;
          // Async: wait half a bit to recheck the start bit at its middle
          s_next.rcnt = {1'b0, s_reg.cfg.baud[11:1]};
          s_next.rst = s_reg.cfg.sync ? UTB_RX_DATA : UTB_RX_START;
        end
      end
      UTB_RX_START: begin
        if (rx_tick) begin
          s_next.rst = serial_in_pin_in ? UTB_RX_IDLE : UTB_RX_DATA;
        end
      end
      UTB_RX_DATA: begin
        if (rx_tick) begin
          s_next.rsh[s_reg.rbit] = serial_in_pin_in;
          if (s_reg.rbit == nbits - 4'h1) begin
            s_next.rst = s_reg.cfg.p_hi ? UTB_RX_PAR : UTB_RX_STOP;
          end else begin
            s_next.rbit = s_reg.rbit + 4'h1;
          end
        end
      end
      UTB_RX_PAR: begin
        if (rx_tick) begin
          s_next.rpar = serial_in_pin_in;
          s_next.rst = UTB_RX_STOP;
        end
      end
      UTB_RX_STOP: begin
        if (rx_tick) begin
          // First stop ends the frame; line idles high through a second one
          s_next.rst = UTB_RX_IDLE;
          word = {3'b000, s_reg.rsh};
          word[`UTB_W_FE] = ~serial_in_pin_in;
          word[`UTB_W_PE] = s_reg.cfg.p_hi &
                            ((^s_reg.rsh) ^ s_reg.cfg.p_odd ^ s_reg.rpar);
          if (s_next.fcnt != `UTB_FIFO_FULL) begin
            word[`UTB_W_DOR] = s_reg.dor_pend;
            s_next.fifo[s_next.fcnt[0]] = word;
            s_next.fcnt = s_next.fcnt + 2'h1;
            s_next.dor_pend = 1'b0;
          end else begin
            s_next.rwait = 1'b1;
            s_next.rwait_word = word;
          end
        end
      end
      default: s_next.rst = UTB_RX_IDLE;
    endcase

    // Receiver off is immediate and flushes everything held
    if (!s_reg.cfg.rxen) begin
      s_next.rst = UTB_RX_IDLE;
      s_next.fcnt = 2'h0;
      s_next.rwait = 1'b0;
      s_next.dor_pend = 1'b0;
    end

    // Transmitter stays on until both buffer and shifter are drained
    s_next.tx_act = s_next.cfg.txen | (s_reg.tx_act &
                    (s_next.tst != UTB_TX_IDLE || s_next.tbuf_full));
    unique case (s_next.tst)
      UTB_TX_START: s_next.txd = 1'b0;
      UTB_TX_DATA: s_next.txd = s_next.tsh[s_next.tbit];
      UTB_TX_PAR: s_next.txd = s_next.tpar;
      default: s_next.txd = 1'b1;
    endcase
    s_next.irq_empty = s_next.cfg.udrie & ~s_next.tbuf_full & global_irq_en_in;
    s_next.irq_done = s_next.cfg.txcie & s_next.tx_done & global_irq_en_in;
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_reg <= '0;
      s_reg.hready <= 1'b1;
      s_reg.txd <= 1'b1;
      s_reg.cfg.csz <= `UTB_CSZ_RST;
      s_reg.cfg.baud <= `UTB_BAUD_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state flops; hresp is tied low
  assign hrdata = s_reg.hrdata;
  assign hreadyout = s_reg.hready;
  assign hresp = 1'b0;
  assign serial_out_pin_out = s_reg.txd;
  assign serial_out_oe_out = s_reg.tx_act;
  assign rx_pin_claim_out = s_reg.cfg.rxen;
  assign irq_empty_out = s_reg.irq_empty;
  assign irq_done_out = s_reg.irq_done;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_data_write;
    s_reg.wr_pend && s_reg.wr_addr == `UTB_A_DATA;
  endsequence
  sequence s_last_stop;
    (s_reg.tst == UTB_TX_STOP1 && !s_reg.cfg.stop2 && tx_tick) ||
    (s_reg.tst == UTB_TX_STOP2 && tx_tick);
  endsequence

  AST_WRITE_FILLS: assert property (s_data_write |=> s_reg.tbuf_full)
    else $error("data write did not fill the transmit buffer");
  AST_EMPTY_IRQ: assert property (irq_empty_out == (!s_reg.tbuf_full && s_reg.cfg.udrie && $past(global_irq_en_in)))
    else $error("empty interrupt without empty buffer");
  AST_DONE_SET: assert property (s_last_stop ##0 !s_reg.tbuf_full |=> s_reg.tx_done)
    else $error("done flag missed after last stop bit");
  AST_DONE_ACK: assert property ((tx_done_ack_in && s_reg.tst == UTB_TX_IDLE) |=> !s_reg.tx_done)
    else $error("service did not clear done flag");
  AST_DONE_IRQ: assert property ($rose(s_reg.tx_done) && s_reg.cfg.txcie |-> irq_done_out == $past(global_irq_en_in))
    else $error("done interrupt wrong at flag set");
  AST_PARITY_SLOT: assert property ((s_reg.tst == UTB_TX_DATA && tx_tick && s_reg.tbit == nbits - 4'h1 && s_reg.cfg.p_hi) |=> serial_out_pin_out == s_reg.tpar)
    else $error("parity bit not after last data bit");
  AST_TX_DRAIN: assert property ((!s_reg.cfg.txen && s_reg.tst != UTB_TX_IDLE) |-> serial_out_oe_out)
    else $error("transmitter released before draining");
  AST_RX_FLUSH: assert property (!s_reg.cfg.rxen |=> s_reg.fcnt == 2'h0)
    else $error("receive buffer not flushed when disabled");
  AST_OVERRUN: assert property ((s_reg.rst == UTB_RX_IDLE && s_reg.cfg.rxen && !s_reg.cfg.sync && !serial_in_pin_in && s_reg.rwait && s_reg.fcnt == `UTB_FIFO_FULL && !(hsel && htrans[1] && hready)) |=> s_reg.dor_pend)
    else $error("overrun not flagged");
endmodule // utb_core
`default_nettype wire

// >>> verif/utb_remote_model.sv
// Remote serial party: sends frames to the port and samples its output
`timescale 1ns/1ps
`default_nettype none
module utb_remote_model (
  input wire logic clk_in,
  input wire logic txd_in,
  output logic rxd_out,
  output logic sclk_out
);
  // Line idles high; external clock stands low between frames
  initial begin
    rxd_out = 1'b1;
    sclk_out = 1'b0;
  end
  // One bit of bc clocks; sync edge mid-bit so the data has settled
  task automatic bit_time(input logic b, input int bc, input logic sy);
    rxd_out <= b;
    repeat (bc / 2) @(posedge clk_in);
    sclk_out <= sy;
    repeat (bc / 2) @(posedge clk_in);
    sclk_out <= 1'b0;
  endtask
  // Start, data LSB first, parity, stop, idle; err flips parity or stop
  task automatic send(input logic [8:0] d, input int nb, input logic pe, od,
                      input logic [1:0] err, input int bc, input logic sy);
    logic p;
    p = od ^ err[0];
    bit_time(1'b0, bc, sy);
    for (int i = 0; i < nb; i++) begin
      bit_time(d[i], bc, sy);
      p = p ^ d[i];
    end
    if (pe) begin
      bit_time(p, bc, sy);
    end
    bit_time(~err[1], bc, sy);
    bit_time(1'b1, bc, 1'b0);
  endtask
  // Mid-bit sampling of one frame from the port
  task automatic recv(input int nb, input logic pe, input int bc,
                      output logic [8:0] d, output logic pb, output logic sb);
    d = 9'h000;
    pb = 1'b0;
    while (txd_in !== 1'b0) @(posedge clk_in);
    repeat (bc / 2) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      repeat (bc) @(posedge clk_in);
      d[i] = txd_in;
    end
    if (pe) begin
      repeat (bc) @(posedge clk_in);
      pb = txd_in;
    end
    repeat (bc) @(posedge clk_in);
    sb = txd_in;
  endtask
endmodule // utb_remote_model
`default_nettype wire

// >>> verif/utb_core_test.sv
// Self-checking bench for the serial port core
`timescale 1ns/1ps
`default_nettype none
`include "utb_consts.svh"
module utb_core_test;
  import utb_pkg::*;
  localparam int BC = 4; // Bit time with baud register 3
  logic clk_sys_in, rst_b_in, hsel, hwrite, rxd, sclk, gie, ack;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic hreadyout, hresp, txd, oe, claim, irq_e, irq_d, pb, sb;
  logic [8:0] rd9;
  int n_fail, num_checks;

  utb_core utb_core_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .serial_in_pin_in(rxd), .sync_clock_pin_in(sclk), .global_irq_en_in(gie),
    .tx_done_ack_in(ack), .serial_out_pin_out(txd), .serial_out_oe_out(oe),
    .rx_pin_claim_out(claim), .irq_empty_out(irq_e), .irq_done_out(irq_d));
  utb_remote_model utb_remote_model_i (.clk_in(clk_sys_in), .txd_in(txd), .rxd_out(rxd),
    .sclk_out(sclk));

  // 40 MHz system clock
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // Wait for the slave's ready; only the watchdog ends a stuck wait
  task automatic rdy();
    @(posedge clk_sys_in);
    while (hreadyout !== 1'b1) begin
      @(posedge clk_sys_in);
    end
  endtask
  // Single AHB-Lite word transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    rdy();
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rv, {24'h0, e});
  endtask
  task automatic t_reset();
    chk({28'h0, txd, oe, claim, hresp}, 32'h0000_0008);
    rdc(`UTB_A_STAT, 8'h20);
    rdc(`UTB_A_CTRLB, 8'h00);
    rdc(`UTB_A_BAUD, 8'h0f);
    rdc(8'h40, 8'h00);
  endtask
  // Back-to-back frames, flag timing, done request and both clears
  task automatic t_tx();
    int n;
    gie <= 1'b1;
    wr(`UTB_A_CTRLC, 8'h06);
    wr(`UTB_A_CTRLB, 8'h48);
    fork
      begin
        utb_remote_model_i.recv(8, 1'b0, BC, rd9, pb, sb);
        chk({23'h0, rd9}, 32'h0000_00a5);
        n = 0;
        while (txd !== 1'b0 && n < 4) begin
          clks(1);
          n++;
        end
        chk({31'h0, txd}, 32'h0000_0000);
        utb_remote_model_i.recv(8, 1'b0, BC, rd9, pb, sb);
        chk({22'h0, sb, rd9}, 32'h0000_023c);
      end
      begin
        wr(`UTB_A_DATA, 8'ha5);
        wr(`UTB_A_DATA, 8'h3c);
        rdc(`UTB_A_STAT, 8'h00);
      end
    join
    n = 0;
    while (irq_d !== 1'b1 && n < 3 * BC) begin
      clks(1);
      n++;
    end
    chk({31'h0, irq_d}, 32'h0000_0001);
    rdc(`UTB_A_STAT, 8'h60);
    chk({31'h0, irq_e}, 32'h0000_0000);
    gie <= 1'b0;
    clks(2);
    chk({31'h0, irq_d}, 32'h0000_0000);
    gie <= 1'b1;
    ack <= 1'b1;
    clks(1);
    ack <= 1'b0;
    rdc(`UTB_A_STAT, 8'h20);
    fork
      utb_remote_model_i.recv(8, 1'b0, BC, rd9, pb, sb);
      wr(`UTB_A_DATA, 8'h81);
    join
    clks(BC);
    rdc(`UTB_A_STAT, 8'h60);
    wr(`UTB_A_STAT, 8'h40);
    rdc(`UTB_A_STAT, 8'h20);
  endtask
  // Disable lands only after shifter and buffer drain
  task automatic t_dis();
    fork
      begin
        utb_remote_model_i.recv(8, 1'b0, BC, rd9, pb, sb);
        chk({23'h0, rd9}, 32'h0000_005a);
        utb_remote_model_i.recv(8, 1'b0, BC, rd9, pb, sb);
        chk({23'h0, rd9}, 32'h0000_0069);
      end
      begin
        wr(`UTB_A_DATA, 8'h5a);
        wr(`UTB_A_DATA, 8'h69);
        wr(`UTB_A_CTRLB, 8'h00);
        chk({31'h0, oe}, 32'h0000_0001);
      end
    join
    clks(BC);
    chk({30'h0, oe, txd}, 32'h0000_0001);
  endtask
  // Parity kinds, short and nine-bit transmit characters
  task automatic t_par();
    logic [7:0] cc [3] = '{8'h44, 8'h64, 8'h0e};
    logic [7:0] cb [3] = '{8'h08, 8'h08, 8'h09};
    logic [7:0] dd [3] = '{8'hb5, 8'hb5, 8'h5a};
    logic [9:0] ex [3] = '{10'h035, 10'h235, 10'h15a};
    int nb [3] = '{7, 7, 9};
    for (int i = 0; i < 3; i++) begin
      wr(`UTB_A_CTRLC, cc[i]);
      wr(`UTB_A_CTRLB, cb[i]);
      fork
        utb_remote_model_i.recv(nb[i], cc[i][6], BC, rd9, pb, sb);
        wr(`UTB_A_DATA, dd[i]);
      join
      chk({22'h0, pb, rd9}, {22'h0, ex[i]});
      clks(BC);
    end
    wr(`UTB_A_CTRLB, 8'h00);
  endtask
  // Empty request follows enable and global gate
  task automatic t_irq();
    wr(`UTB_A_CTRLB, 8'h28);
    clks(2);
    chk({31'h0, irq_e}, 32'h0000_0001);
    gie <= 1'b0;
    clks(2);
    chk({31'h0, irq_e}, 32'h0000_0000);
    gie <= 1'b1;
    wr(`UTB_A_CTRLB, 8'h08);
    clks(2);
    chk({31'h0, irq_e}, 32'h0000_0000);
  endtask
  // Formats and per-entry error flags on receive
  task automatic t_rx();
    logic [7:0] cc [5] = '{8'h06, 8'h00, 8'h0e, 8'h46, 8'h06};
    logic [8:0] sd [5] = '{9'h0c3, 9'h1ff, 9'h1a5, 9'h033, 9'h055};
    logic [1:0] er [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
    logic [7:0] es [5] = '{8'ha0, 8'ha0, 8'ha0, 8'ha4, 8'hb0};
    logic [7:0] ed [5] = '{8'hc3, 8'h1f, 8'ha5, 8'h33, 8'h55};
    int nb [5] = '{8, 5, 9, 8, 8};
    wr(`UTB_A_CTRLB, 8'h10);
    // Earlier transmit scenarios leave the done flag set
    wr(`UTB_A_STAT, 8'h40);
    chk({31'h0, claim}, 32'h0000_0001);
    for (int i = 0; i < 5; i++) begin
      wr(`UTB_A_CTRLC, cc[i]);
      utb_remote_model_i.send(sd[i], nb[i], cc[i][6], 1'b0, er[i], BC, 1'b0);
      rdc(`UTB_A_STAT, es[i]);
      if (i == 2) rdc(`UTB_A_CTRLB, 8'h12);
      rdc(`UTB_A_DATA, ed[i]);
      rdc(`UTB_A_STAT, 8'h20);
    end
  endtask
  // Overrun after a full buffer, then flush on disable
  task automatic t_ovr();
    wr(`UTB_A_CTRLC, 8'h06);
    for (int i = 0; i < 4; i++) begin
      utb_remote_model_i.send(9'h010 + 9'(i), 8, 1'b0, 1'b0, 2'h0, BC, 1'b0);
    end
    rdc(`UTB_A_STAT, 8'ha0);
    rdc(`UTB_A_DATA, 8'h10);
    rdc(`UTB_A_STAT, 8'ha0);
    rdc(`UTB_A_DATA, 8'h11);
    rdc(`UTB_A_STAT, 8'ha8);
    rdc(`UTB_A_DATA, 8'h13);
    rdc(`UTB_A_STAT, 8'h20);
    utb_remote_model_i.send(9'h077, 8, 1'b0, 1'b0, 2'h0, BC, 1'b0);
    wr(`UTB_A_CTRLB, 8'h00);
    rdc(`UTB_A_STAT, 8'h20);
    chk({31'h0, claim}, 32'h0000_0000);
  endtask
  // Slow external clock; the internal bit rate would misread it
  task automatic t_sync();
    wr(`UTB_A_CTRLB, 8'h10);
    wr(`UTB_A_CTRLC, 8'h07);
    utb_remote_model_i.send(9'h096, 8, 1'b0, 1'b0, 2'h0, 3 * BC, 1'b1);
    rdc(`UTB_A_DATA, 8'h96);
  endtask
  // Reset sequence then scenarios
  initial begin
    rst_b_in = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    gie = 1'b0;
    ack = 1'b0;
    n_fail = 0;
    num_checks = 0;
    clks(10);
    rst_b_in <= 1'b1;
    t_reset();
    wr(`UTB_A_BAUD, 8'h03);
    t_tx();
    t_dis();
    t_par();
    t_irq();
    t_rx();
    t_ovr();
    t_sync();
    finish_test();
  end
  // Watchdog well beyond the expected thousand or so cycles
  initial begin
    clks(20000);
    n_fail++;
    finish_test();
  end
endmodule // utb_core_test
`default_nettype wire
